// ===== design/console_port_control.sv
// driver-side console port controller with AXI4-Lite command registers
//
// Notes on behaviour
// - output characters go as buffers into the chosen port's transmit queue.
// - never offer device-readable buffers to receive, nor writable to transmit.
// - device messages arrive on control receive, ours leave on control transmit (here on the queue in REG_TXQ, which resets to 3 but is writable).
// - message is 32-bit port number, 16-bit event, 16-bit argument, little-endian.
// - send event 0 at start; argument 1 success, 0 failure; port ignored.
// - answer each port add with event 3, argument 1 success or 0 failure (here one ack is held; a second add before it leaves replaces it).
// - event 6 reports open state: 0 closed, 1 open, either direction.
// - with multiport negotiated, readiness message is always sent.
// - on console designation, reply open message with argument 1.
// - legacy mode uses guest native byte order for message fields.
// - legacy without any-layout: one descriptor per control buffer.
// - queues: 0/1 port 0, 2/3 control, then pairs for later ports.
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module console_port_control
  import console_ctl_pkg::*;
#(
  parameter int PORTS = 32
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // control receive queue: one 32-bit word per beat from the device
  input  wire logic [31:0] rxWord,
  input  wire logic        rxValid,
  input  wire logic        rxLast,
  output      logic        rxReady,
  // control transmit queue: one 32-bit word per beat to the device
  output      logic [31:0] txWord,
  output      logic        txValid,
  output      logic        txLast,
  output      logic [15:0] txQueue,
  input  wire logic        txReady,
  // configuration change for the size feature
  input  wire logic        cfgChange,
  input  wire logic [15:0] cfgCols,
  input  wire logic [15:0] cfgRows
);
  import console_ctl_pkg::*;

  // port maps are one word wide, so the port limit must fit in 32 bits
  if (PORTS < 1 || PORTS > 32) begin : badPorts
    $error("PORTS must be 1..32");
  end

  // byte order: little-endian unless legacy big-endian guest
  function automatic logic [31:0] ord32(input logic [31:0] v, input logic sw);
    ord32 = sw ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
  endfunction
  function automatic logic [15:0] ord16(input logic [15:0] v, input logic sw);
    ord16 = sw ? {v[7:0], v[15:8]} : v;
  endfunction

  logic [31:0] ctrl_r;
  logic [31:0] portMap_r, consMap_r, openMap_r;
  logic [31:0] size_r;
  logic [31:0] lastMsg_r;
  logic [31:0] lastEv_r;
  logic [31:0] errCnt_r;
  logic        readySent_r;
  logic [31:0] sendPort_r;
  logic [31:0] sendEv_r;
  logic        sendReq_r;
  logic [15:0] txQ_r;
  // rx parsing
  logic [1:0]  rxBeat_r;
  logic [31:0] rxPort_r;
  logic        inName_r;
  // pending automatic replies
  // one reply of each kind is held; a second one before the first leaves overwrites it
  logic        ackPend_r, openPend_r;
  logic [31:0] ackPort_r, openPort_r;
  logic        ackOk_r;
  // tx
  txs_t        txs_r, txs_nxt;
  logic [31:0] txW1_r;
  logic [31:0] txWord_r;
  // axi
  logic        awHave_r, wHave_r, bvalid_r, rvalid_r;
  logic [7:0]  awAddr_r;
  logic [31:0] wData_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r;

  wire logic swap = ctrl_r[CTRL_LEGACY] & ctrl_r[CTRL_BIGEND];
  wire logic multi = ctrl_r[CTRL_MULTI];

  // ---------------- receive side: parse device messages
  // beat 0 port number, beat 1 {argument, event}; later beats carry resize or name
  assign rxReady = 1'b1;
  wire logic        rxTake   = rxValid & rxReady;
  wire logic [31:0] rxPortIn = ord32(rxWord, swap);
  wire logic [15:0] rxEvIn   = ord16(rxWord[15:0], swap);
  wire logic [15:0] rxArgIn  = ord16(rxWord[31:16], swap);
  wire logic        rxHdr    = rxTake & (rxBeat_r == 2'd1) & ~inName_r;
  wire logic        portOk   = rxPort_r < 32'(PORTS);
  wire logic [4:0]  pIdx     = rxPort_r[4:0];
  wire logic        exists   = portMap_r[pIdx];
  wire logic        rsz      = rxTake & (rxBeat_r == 2'd2) & ~inName_r;
  wire logic        ackSet   = rxHdr & (rxEvIn == EV_PORT_ADD);
  wire logic        openSet  = rxHdr & (rxEvIn == EV_CONSOLE) & portOk & exists;

  // ---------------- transmit arbitration: readiness, ack, open, software
  wire logic txFree    = (txs_r == TX_IDLE);
  wire logic needReady = multi & ~readySent_r;
  wire logic [1:0] pick = needReady  ? 2'd0 :
                          ackPend_r  ? 2'd1 :
                          openPend_r ? 2'd2 :
                          sendReq_r  ? 2'd3 : 2'd0;
  wire logic anyTx     = needReady | (readySent_r & (ackPend_r | openPend_r | sendReq_r));
  wire logic txStart   = txFree & anyTx;
  wire logic [31:0] selPort = (pick == 2'd1) ? ackPort_r : (pick == 2'd2) ? openPort_r :
                              (pick == 2'd3) ? sendPort_r : 32'h0000_0000;
  wire logic [15:0] selEv   = (pick == 2'd0) ? EV_DEV_READY : (pick == 2'd1) ? EV_PORT_READY :
                              (pick == 2'd2) ? EV_PORT_OPEN : sendEv_r[15:0];
  wire logic [15:0] selArg  = (pick == 2'd0) ? {15'h0000, ctrl_r[CTRL_READY_OK]} :
                              (pick == 2'd1) ? {15'h0000, ackOk_r} :
                              (pick == 2'd2) ? 16'h0001 : sendEv_r[31:16];

  always_comb begin
    txs_nxt = txs_r;
    case (txs_r)
      TX_IDLE: if (txStart) txs_nxt = TX_W0;
      TX_W0:   if (txReady) txs_nxt = TX_W1;
      TX_W1:   if (txReady) txs_nxt = TX_IDLE;
      default: txs_nxt = TX_IDLE;
    endcase
  end

  assign txValid = (txs_r == TX_W0) | (txs_r == TX_W1);
  assign txLast  = (txs_r == TX_W1);
  assign txWord  = txWord_r;
  assign txQueue = txQ_r;

  // ---------------- axi slave
  // address and data ready fall while a response waits, so one write is in flight
  assign s_axi_awready = ~awHave_r & ~bvalid_r;
  assign s_axi_wready  = ~wHave_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  wire logic doWrite = awHave_r & wHave_r & ~bvalid_r;
  wire logic wrCtrl  = doWrite & (awAddr_r == REG_CTRL);
  wire logic wrSend  = doWrite & (awAddr_r == REG_SEND) & ~sendReq_r;
  wire logic wrTxq   = doWrite & (awAddr_r == REG_TXQ);
  wire logic wrOk    = (awAddr_r == REG_CTRL) | (awAddr_r == REG_TXQ) |
                       ((awAddr_r == REG_SEND) & ~sendReq_r) | (awAddr_r == REG_PORT_MAP);
  wire logic [7:0] ra = s_axi_araddr;
  wire logic rdHit = (ra == REG_CTRL) | (ra == REG_STATUS) | (ra == REG_PORT_MAP) |
                     (ra == REG_CONS_MAP) | (ra == REG_OPEN_MAP) | (ra == REG_SIZE) |
                     (ra == REG_LAST_MSG) | (ra == REG_LAST_EV) | (ra == REG_SEND) | (ra == REG_TXQ);
  wire logic [31:0] status = {errCnt_r[15:0], 8'h00, 1'b0, txs_r, sendReq_r, openPend_r, ackPend_r, readySent_r};
  wire logic [31:0] rdMux =
    (ra == REG_CTRL)     ? ctrl_r    : (ra == REG_STATUS)   ? status    :
    (ra == REG_PORT_MAP) ? portMap_r : (ra == REG_CONS_MAP) ? consMap_r :
    (ra == REG_OPEN_MAP) ? openMap_r : (ra == REG_SIZE)     ? size_r    :
    (ra == REG_LAST_MSG) ? lastMsg_r : (ra == REG_LAST_EV)  ? lastEv_r  :
    (ra == REG_SEND)     ? sendEv_r  : (ra == REG_TXQ)      ? {16'h0000, txQ_r} : 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      awHave_r <= 1'b0;
      wHave_r  <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r  <= 32'h0000_0000;
      bresp_r  <= RESP_OKAY;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
      end
      if (doWrite) begin
        awHave_r <= 1'b0;
        wHave_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wrOk ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r & s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rdMux;
        rresp_r  <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r & s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ---------------- controller state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_r      <= CTRL_RESET;
      portMap_r   <= 32'h0000_0000;
      consMap_r   <= 32'h0000_0000;
      openMap_r   <= 32'h0000_0000;
      size_r      <= 32'h0000_0000;
      lastMsg_r   <= 32'h0000_0000;
      lastEv_r    <= 32'h0000_0000;
      errCnt_r    <= 32'h0000_0000;
      readySent_r <= 1'b0;
      sendPort_r  <= 32'h0000_0000;
      sendEv_r    <= 32'h0000_0000;
      sendReq_r   <= 1'b0;
      txQ_r       <= Q_CTRL_TX;
      rxBeat_r    <= 2'd0;
      rxPort_r    <= 32'h0000_0000;
      inName_r    <= 1'b0;
      ackPend_r   <= 1'b0;
      openPend_r  <= 1'b0;
      ackPort_r   <= 32'h0000_0000;
      openPort_r  <= 32'h0000_0000;
      ackOk_r     <= 1'b0;
      txs_r       <= TX_IDLE;
      txW1_r      <= 32'h0000_0000;
      txWord_r    <= 32'h0000_0000;
    end else begin
      txs_r <= txs_nxt;
      if (wrCtrl) begin
        ctrl_r <= wData_r;
        // dropping multiport re-arms the readiness message
        if (~wData_r[CTRL_MULTI]) readySent_r <= 1'b0;
      end
      if (wrTxq) txQ_r <= wData_r[15:0];
      // a software message takes its port from the last received message
      if (wrSend) begin
        sendEv_r   <= wData_r;
        sendPort_r <= lastMsg_r;
        sendReq_r  <= 1'b1;
      end
      // size change from configuration space, port 0 only
      if (cfgChange & ctrl_r[CTRL_SIZE_F]) size_r <= {cfgRows, cfgCols};
      // parse incoming control messages
      if (rxTake) begin
        rxBeat_r <= rxLast ? 2'd0 : (rxBeat_r == 2'd3 ? 2'd3 : rxBeat_r + 2'd1);
        if (rxLast) inName_r <= 1'b0;
        if (rxBeat_r == 2'd0 && !inName_r) rxPort_r <= rxPortIn;
        if (rxHdr) begin
          lastMsg_r <= rxPort_r;
          lastEv_r  <= {rxArgIn, rxEvIn};
          case (rxEvIn)
            EV_PORT_ADD: begin
              if (portOk & ~exists) begin
                portMap_r[pIdx] <= 1'b1;
                ackPend_r <= 1'b1;
                ackPort_r <= rxPort_r;
                ackOk_r   <= 1'b1;
              end else begin
                errCnt_r  <= errCnt_r + 32'd1;
                ackPend_r <= 1'b1;
                ackPort_r <= rxPort_r;
                ackOk_r   <= 1'b0;
              end
            end
            EV_PORT_REM: begin
              if (portOk & exists) begin
                portMap_r[pIdx] <= 1'b0;
                consMap_r[pIdx] <= 1'b0;
                openMap_r[pIdx] <= 1'b0;
              end else errCnt_r <= errCnt_r + 32'd1;
            end
            EV_CONSOLE: begin
              if (portOk & exists) begin
                consMap_r[pIdx] <= 1'b1;
                openPend_r <= 1'b1;
                openPort_r <= rxPort_r;
              end else errCnt_r <= errCnt_r + 32'd1;
            end
            EV_PORT_OPEN: if (portOk) openMap_r[pIdx] <= rxArgIn[0];
            EV_PORT_NAME: inName_r <= ~rxLast;
            EV_RESIZE: ;
            default: errCnt_r <= errCnt_r + 32'd1;
          endcase
        end
        if (rsz & (lastEv_r[15:0] == EV_RESIZE)) begin
          size_r <= {ord16(rxWord[31:16], swap), ord16(rxWord[15:0], swap)};
        end
      end
      // start of an outgoing message on the queue in REG_TXQ, control transmit after reset
      if (txStart) begin
        txW1_r   <= {ord16(selArg, swap), ord16(selEv, swap)};
        txWord_r <= ord32(selPort, swap);
        case (pick)
          2'd0: readySent_r <= 1'b1;
          // a reply raised in this very cycle stays pending: set wins over clear
          2'd1: if (!ackSet) ackPend_r <= 1'b0;
          2'd2: begin
            if (!openSet) openPend_r <= 1'b0;
            if (openPort_r < 32'(PORTS)) openMap_r[openPort_r[4:0]] <= 1'b1;
          end
          2'd3: sendReq_r   <= 1'b0;
          default: ;
        endcase
      end
      if (txs_r == TX_W0 && txReady) txWord_r <= txW1_r;
    end
  end
endmodule

// ===== design/console_ctl_pkg.sv
// package: constants for the console port driver-side controller
package console_ctl_pkg;
  // control event codes
  localparam logic [15:0] EV_DEV_READY  = 16'h0000;
  localparam logic [15:0] EV_PORT_ADD   = 16'h0001;
  localparam logic [15:0] EV_PORT_REM   = 16'h0002;
  localparam logic [15:0] EV_PORT_READY = 16'h0003;
  localparam logic [15:0] EV_CONSOLE    = 16'h0004;
  localparam logic [15:0] EV_RESIZE     = 16'h0005;
  localparam logic [15:0] EV_PORT_OPEN  = 16'h0006;
  localparam logic [15:0] EV_PORT_NAME  = 16'h0007;
  // queue numbering
  localparam logic [15:0] Q_CTRL_RX     = 16'h0002;
  localparam logic [15:0] Q_CTRL_TX     = 16'h0003;
  localparam logic [15:0] Q_PORT1_BASE  = 16'h0004;
  // own register offsets (byte addresses)
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_PORT_MAP  = 8'h08;
  localparam logic [7:0]  REG_CONS_MAP  = 8'h0C;
  localparam logic [7:0]  REG_OPEN_MAP  = 8'h10;
  localparam logic [7:0]  REG_SIZE      = 8'h14;
  localparam logic [7:0]  REG_LAST_MSG  = 8'h18;
  localparam logic [7:0]  REG_LAST_EV   = 8'h1C;
  localparam logic [7:0]  REG_SEND      = 8'h20;
  localparam logic [7:0]  REG_TXQ       = 8'h24;
  // control register fields
  localparam int CTRL_MULTI   = 0;
  localparam int CTRL_LEGACY  = 1;
  localparam int CTRL_BIGEND  = 2;
  localparam int CTRL_SIZE_F  = 3;
  localparam int CTRL_READY_OK = 4;
  // resets
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0011;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_W0   = 3'b001,
    TX_W1   = 3'b010,
    TX_DONE = 3'b011
  } txs_t;
endpackage

// ===== verif/console_port_control_chk.sv
// checker: concurrent properties on the console controller ports
`timescale 1ns/1ps
module console_port_control_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // axi4-lite handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // control queues
  input wire logic        rxValid,
  input wire logic        rxReady,
  input wire logic [31:0] txWord,
  input wire logic        txValid,
  input wire logic        txLast,
  input wire logic [15:0] txQueue,
  input wire logic        txReady
);
  import console_ctl_pkg::*;
  logic inFrame_r;
  logic readySeen_r;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // tracks which beat of a message is on the queue and whether readiness went out
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      inFrame_r   <= 1'b0;
      readySeen_r <= 1'b0;
    end else if (txValid && txReady) begin
      inFrame_r <= !txLast;
      if (txLast && txWord[15:0] == EV_DEV_READY) begin
        readySeen_r <= 1'b1;
      end
    end
  end
  sequence beatStalled;
    txValid && !txReady;
  endsequence
  sequence bothTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_tx_hold: assert property (beatStalled |=> txValid && $stable(txWord) && $stable(txLast))
    else $error("tx beat changed before it was taken");
  a_frame_beats: assert property (txValid |-> txLast == inFrame_r)
    else $error("control message is not two beats");
  a_ctrl_queue: assert property (txValid |-> txQueue == Q_CTRL_TX)
    else $error("control message on wrong queue");
  a_ready_first: assert property (txValid && txLast && !readySeen_r |-> txWord[15:0] == EV_DEV_READY)
    else $error("message sent before readiness");
  a_rx_accept: assert property (rxValid |-> rxReady)
    else $error("control receive beat refused");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (bothTaken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule
bind console_port_control console_port_control_chk chk (
  .core_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .rxValid, .rxReady, .txWord, .txValid, .txLast,
  .txQueue, .txReady
);

// ===== verif/console_dev_model.sv
// partner model: device side of the console control queues
`timescale 1ns/1ps
module console_dev_model #(
  parameter int PORT_LIMIT = 4
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // control receive queue toward the controller
  output      logic [31:0] rxWord,
  output      logic        rxValid,
  output      logic        rxLast,
  input  wire logic        rxReady,
  // control transmit queue from the controller
  input  wire logic [31:0] txWord,
  input  wire logic        txValid,
  input  wire logic        txLast,
  output      logic        txReady
);
  import console_ctl_pkg::*;
  logic [63:0]           got[$];
  logic [31:0]           firstWord;
  logic [PORT_LIMIT-1:0] present = '0;
  logic                  readyOk = 1'b0;
  logic                  slow = 1'b0;
  logic [1:0]            tick = 2'b00;
  initial begin
    rxWord  = 32'h0000_0000;
    rxValid = 1'b0;
    rxLast  = 1'b0;
  end
  // consumer answers promptly or only every fourth cycle
  always @(posedge core_clk) begin
    tick    <= tick + 2'd1;
    txReady <= !slow || (tick == 2'd0);
    if (sys_rst) begin
      readyOk <= 1'b0;
    end else if (txValid && txReady) begin
      if (!txLast) begin
        firstWord <= txWord;
      end else begin
        got.push_back({firstWord, txWord});
        if (txWord == {16'h0001, EV_DEV_READY}) begin
          readyOk <= 1'b1;
        end
      end
    end
  end
  task automatic sendMsg(input logic [31:0] port, input logic [15:0] ev, input logic [15:0] arg,
                         input logic [31:0] extra, input logic hasExtra, input logic chk);
    int n;
    n = 0;
    while (!readyOk && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    if (chk && ev == EV_PORT_ADD) begin
      if (port >= PORT_LIMIT || present[port]) return;
      present[port] = 1'b1;
    end
    if (chk && ev == EV_PORT_REM) begin
      if (port >= PORT_LIMIT || !present[port]) return;
      present[port] = 1'b0;
    end
    rxValid <= 1'b1;
    rxLast  <= 1'b0;
    rxWord  <= port;
    do @(posedge core_clk); while (!rxReady);
    rxWord <= {arg, ev};
    rxLast <= !hasExtra;
    do @(posedge core_clk); while (!rxReady);
    if (hasExtra) begin
      rxWord <= extra;
      rxLast <= 1'b1;
      do @(posedge core_clk); while (!rxReady);
    end
    rxValid <= 1'b0;
    rxLast  <= 1'b0;
    rxWord  <= ~rxWord;
  endtask
endmodule

// ===== verif/tb_top.sv
// testbench: register and control-queue sequences for the console controller
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin numErrors++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  import console_ctl_pkg::*;
  logic        core_clk = 1'b0, sys_rst = 1'b1, cfgChange = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rxWord, txWord, rd, p;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [15:0] cfgCols = 16'h0000, cfgRows = 16'h0000, txQueue;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        rxValid, rxLast, rxReady, txValid, txLast, txReady;
  logic [63:0] msg;
  int          numErrors = 0;
  int          checked = 0;
  always #25 core_clk = ~core_clk;
  console_port_control #(.PORTS(4)) DUT (
    .core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rxWord, .rxValid, .rxLast, .rxReady, .txWord, .txValid, .txLast, .txQueue, .txReady,
    .cfgChange, .cfgCols, .cfgRows
  );
  console_dev_model #(.PORT_LIMIT(4)) dev (
    .core_clk, .sys_rst, .rxWord, .rxValid, .rxLast, .rxReady, .txWord, .txValid, .txLast, .txReady
  );
  task automatic axWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone  = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge core_clk);
      if (!awDone && s_axi_awready) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wDone && s_axi_wready) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  task automatic axRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic expRead(input logic [7:0] a, input logic [31:0] e);
    axRead(a, rd, rs);
    `CHK({rs, rd}, {RESP_OKAY, e})
  endtask
  // an unknown expectation skips that word
  task automatic expMsg(input logic [31:0] port, input logic [31:0] w1);
    int n;
    n = 0;
    while (dev.got.size() == 0 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    msg = (n < 2000) ? dev.got.pop_front() : 64'hxxxx_xxxx_xxxx_xxxx;
    if (port !== 32'hxxxx_xxxx) `CHK(msg[63:32], port)
    if (w1 !== 32'hxxxx_xxxx) `CHK(msg[31:0], w1)
  endtask
  task automatic summarize;
    $display("errors %0d, checks %0d", numErrors, checked);
    if (numErrors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    expRead(REG_CTRL, CTRL_RESET);
    expRead(REG_TXQ, {16'h0000, Q_CTRL_TX});
    axRead(8'h40, rd, rs);
    `CHK({rs, rd}, {RESP_SLVERR, 32'h0000_0000})
    axWrite(8'h44, 32'h0000_0001, rs);
    `CHK(rs, RESP_SLVERR)
    expMsg(32'hxxxx_xxxx, {16'h0001, EV_DEV_READY});
    dev.slow = 1'b1;
    for (p = 32'h1; p < 32'h4; p++) begin
      dev.sendMsg(p, EV_PORT_ADD, 16'h0000, 32'h0000_0000, 1'b0, 1'b1);
      expMsg(p, {16'h0001, EV_PORT_READY});
    end
    expRead(REG_PORT_MAP, 32'h0000_000E);
    dev.sendMsg(32'h4, EV_PORT_ADD, 16'h0000, 32'h0000_0000, 1'b0, 1'b0);
    expMsg(32'h4, {16'h0000, EV_PORT_READY});
    dev.sendMsg(32'h1, EV_PORT_ADD, 16'h0000, 32'h0000_0000, 1'b0, 1'b0);
    expMsg(32'h1, {16'h0000, EV_PORT_READY});
    expRead(REG_STATUS, 32'h0002_0001);
    expRead(REG_PORT_MAP, 32'h0000_000E);
    for (p = 32'h2; p < 32'h4; p++) begin
      dev.sendMsg(p, EV_CONSOLE, 16'h0000, 32'h0000_0000, 1'b0, 1'b1);
      expMsg(p, {16'h0001, EV_PORT_OPEN});
    end
    expRead(REG_CONS_MAP, 32'h0000_000C);
    dev.sendMsg(32'h1, EV_PORT_OPEN, 16'h0001, 32'h0000_0000, 1'b0, 1'b1);
    axRead(REG_OPEN_MAP, rd, rs);
    `CHK(rd[1], 1'b1)
    dev.sendMsg(32'h0, EV_RESIZE, 16'h0000, 32'h0019_0050, 1'b1, 1'b1);
    expRead(REG_SIZE, 32'h0019_0050);
    dev.sendMsg(32'h1, EV_PORT_NAME, 16'h0000, 32'h6463_6261, 1'b1, 1'b1);
    expRead(REG_LAST_EV, {16'h0000, EV_PORT_NAME});
    dev.sendMsg(32'h2, EV_PORT_REM, 16'h0000, 32'h0000_0000, 1'b0, 1'b1);
    expRead(REG_PORT_MAP, 32'h0000_000A);
    expRead(REG_LAST_MSG, 32'h0000_0002);
    axWrite(REG_SEND, {16'h0000, EV_PORT_OPEN}, rs);
    `CHK(rs, RESP_OKAY)
    expMsg(32'h2, {16'h0000, EV_PORT_OPEN});
    for (p = 32'h0; p < 32'h2; p++) begin
      axWrite(REG_CTRL, p[0] ? 32'h0000_0019 : CTRL_RESET, rs);
      cfgCols   <= p[0] ? 16'h0084 : 16'h0099;
      cfgRows   <= p[0] ? 16'h002B : 16'h0077;
      cfgChange <= 1'b1;
      @(posedge core_clk);
      cfgChange <= 1'b0;
      @(posedge core_clk);
      expRead(REG_SIZE, p[0] ? 32'h002B_0084 : 32'h0019_0050);
    end
    axWrite(REG_CTRL, 32'h0000_0017, rs);
    axWrite(REG_SEND, {16'h0001, EV_PORT_OPEN}, rs);
    expMsg(32'h0200_0000, 32'h0100_0600);
    axWrite(REG_CTRL, CTRL_RESET, rs);
    summarize;
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    numErrors++;
    $display("Error at %0t: watchdog expired", $time);
    summarize;
  end
endmodule
